// ---- qfc_ctrl.sv ----
// quad serial flash control core: clock gate, cs timing, partitions, events
`timescale 1ns/100ps
`default_nettype none
`include "qfc_defines.svh"

// Contract
// - software enable bit gates the serial reference clock on and off.
// - single active-low reset, held until software releases it.
// - 128 locations split: read gets P+1, write gets 128-P.
// - all sources merge into one active-high level interrupt.
// - status bits clear on write one, except the four legacy live bits, which follow their condition; each source masked individually.
// - underflow flag set on slow write data; clears only by reset or one.
// - indirect-complete flag set when a triggered indirect operation ends.
// - queue holds two indirect operations; a third is rejected and flagged.
// - writes to the protected region are refused and flagged.
// - wrapping bursts, split or retry on the data port flag illegal access.
// - watermark flag raised when fill level reaches the programmed watermark.
// - legacy mode receive overflow flag; a new overflow beats a clear.
// - legacy mode four live FIFO conditions act as interrupt sources.
// - a push to a full read partition while an indirect operation is pending raises overflow.
// - address bytes for all transfers, page size for writes, block size for protection.
// - chip-select delays count serial reference clock periods.
// - remap offset applies to direct transfers only.
// - read data sampling is delayed by the programmed capture delay.
// - flash serial clock is the reference clock divided by twice the baud divisor plus one, 2*(baud_div+1).
module qfc_ctrl
   import qfc_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // configuration
   input wire logic ref_clk_en,
   input wire logic legacy_mode,
   input wire logic [3:0] baud_div,
   input wire logic [7:0] cs_gap_dly,
   input wire logic [2:0] rd_capture_dly,
   input wire logic addr_bytes_4,
   input wire logic [4:0] block_shift,
   input wire logic [4:0] page_shift,
   input wire logic [31:0] remap_offset,
   input wire logic wp_en,
   input wire logic wp_inv,
   input wire logic [15:0] wp_low_blk,
   input wire logic [15:0] wp_high_blk,
   input wire logic [6:0] part_split,
   input wire logic [7:0] watermark,
   input wire logic [11:0] irq_mask,
   input wire logic [11:0] irq_clr,
   // indirect operation queue
   input wire logic ind_req,
   input wire logic ind_done,
   output logic ind_accept,
   output logic [1:0] queue_level,
   // sram partitions
   input wire logic rd_push,
   input wire logic rd_pop,
   input wire logic wr_push,
   input wire logic wr_pop,
   output logic [7:0] rd_fill,
   output logic [7:0] wr_fill,
   output logic rd_room,
   output logic wr_room,
   // data port transfers
   input wire logic xfer_req,
   input wire logic xfer_write,
   input wire logic xfer_direct,
   input wire logic [31:0] xfer_addr,
   input wire logic dp_underrun,
   input wire logic dp_wrap_burst,
   input wire logic dp_split,
   input wire logic dp_retry,
   output logic xfer_go,
   output logic xfer_refused,
   output logic [31:0] flash_addr,
   output logic page_last,
   // legacy fifo status
   input wire logic rxf_push,
   input wire logic rxf_full,
   input wire logic rxf_empty,
   input wire logic txf_full,
   // flash pins
   input wire logic cs_req,
   input wire logic flash_miso,
   output logic flash_sclk,
   output logic flash_cs_n,
   output logic rd_bit,
   // interrupt
   output logic irq,
   output logic [11:0] irq_status
);

   function automatic logic [7:0] rd_cap(input logic [6:0] p);
      rd_cap = {1'b0, p} + 8'h01;
   endfunction

   function automatic logic [7:0] wr_cap(input logic [6:0] p);
      wr_cap = `QFC_SRAM_DEPTH - {1'b0, p};
   endfunction

   function automatic logic wp_hit(input logic [31:0] a, input logic [4:0] sh,
                                   input logic [15:0] lo, input logic [15:0] hi,
                                   input logic en, input logic inv);
      logic [31:0] blk;
      logic in_rgn;
      blk = a >> sh;
      in_rgn = (blk[15:0] >= lo) && (blk[15:0] <= hi) && (blk[31:16] == 16'h0000);
      wp_hit = en & (in_rgn ^ inv);
   endfunction

   qfc_irq_if ibus ();

   qfc_irq u_irq (
      .clk_sys (clk_sys),
      .rstn (rstn),
      .bus (ibus)
   );

   // the real gate sits in the clock manager; here the enable marks ref periods
   logic ref_tick;
   assign ref_tick = ref_clk_en;

   // indirect operation queue
   logic q_full;
   logic q_reject;
   logic q_take;
   assign q_full = (queue_level == `QFC_QUEUE_MAX);
   assign q_take = ind_req & ~q_full;
   assign q_reject = ind_req & q_full;

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         queue_level <= 2'h0;
         ind_accept <= 1'b0;
      end else begin
         ind_accept <= q_take;
         queue_level <= queue_level + {1'b0, q_take}
                        - {1'b0, ind_done && (queue_level != 2'h0)};
      end
   end

   // sram partition fill levels
   logic rd_push_ok;
   logic wr_push_ok;
   logic rd_ovf;
   assign rd_room = (rd_fill < rd_cap(part_split));
   assign wr_room = (wr_fill < wr_cap(part_split));
   assign rd_push_ok = rd_push & rd_room;
   assign wr_push_ok = wr_push & wr_room;
   assign rd_ovf = rd_push & ~rd_room & (queue_level != 2'h0);

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         rd_fill <= 8'h00;
      end else begin
         rd_fill <= rd_fill + {7'h00, rd_push_ok} - {7'h00, rd_pop && (rd_fill != 8'h00)};
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         wr_fill <= 8'h00;
      end else begin
         wr_fill <= wr_fill + {7'h00, wr_push_ok} - {7'h00, wr_pop && (wr_fill != 8'h00)};
      end
   end

   // watermark: one event per crossing, a zero watermark never fires
   logic wm_level;
   logic wm_evt;
   assign wm_evt = (watermark != 8'h00) && (rd_fill >= watermark) && !wm_level;

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         wm_level <= 1'b0;
      end else begin
         wm_level <= (watermark != 8'h00) && (rd_fill >= watermark);
      end
   end

   // transfer address path and write protection
   logic prot_hit;
   logic [31:0] base_addr;
   logic [31:0] page_mask;
   assign prot_hit = xfer_req & xfer_write
                     & wp_hit(xfer_addr, block_shift, wp_low_blk, wp_high_blk, wp_en, wp_inv);
   assign base_addr = xfer_direct ? (xfer_addr + remap_offset) : xfer_addr;
   assign page_mask = (32'h0000_0001 << page_shift) - 32'h0000_0001;

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         xfer_go <= 1'b0;
         xfer_refused <= 1'b0;
         flash_addr <= 32'h0000_0000;
         page_last <= 1'b0;
      end else begin
         xfer_go <= xfer_req & ~prot_hit;
         xfer_refused <= prot_hit;
         if (xfer_req && !prot_hit) begin
            flash_addr <= addr_bytes_4 ? base_addr : (base_addr & `QFC_ADDR3_MASK);
            page_last <= xfer_write && ((base_addr & page_mask) == page_mask);
         end
      end
   end

   // chip select with deassert gap counted in reference periods
   qfc_cs_t cs_state;
   logic [7:0] gap_cnt;
   logic [3:0] div_cnt;

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         cs_state <= QFC_CS_IDLE;
         gap_cnt <= 8'h00;
      end else begin
         unique case (cs_state)
            QFC_CS_IDLE: begin
               gap_cnt <= 8'h00;
               if (cs_req && ref_tick) begin
                  cs_state <= QFC_CS_ACTIVE;
               end
            end
            QFC_CS_ACTIVE: begin
               if (!cs_req) begin
                  cs_state <= QFC_CS_GAP;
               end
            end
            QFC_CS_GAP: begin
               if (gap_cnt >= cs_gap_dly) begin
                  cs_state <= QFC_CS_IDLE;
               end else if (ref_tick) begin
                  gap_cnt <= gap_cnt + 8'h01;
               end
            end
            default: begin
               cs_state <= QFC_CS_IDLE;
            end
         endcase
      end
   end

   assign flash_cs_n = (cs_state != QFC_CS_ACTIVE);

   // serial clock: half period is baud_div+1 reference periods
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         flash_sclk <= 1'b0;
         div_cnt <= 4'h0;
      end else if (cs_state != QFC_CS_ACTIVE) begin
         flash_sclk <= 1'b0;
         div_cnt <= 4'h0;
      end else if (ref_tick) begin
         if (div_cnt == baud_div) begin
            flash_sclk <= ~flash_sclk;
            div_cnt <= 4'h0;
         end else begin
            div_cnt <= div_cnt + 4'h1;
         end
      end
   end

   // read capture: pin synchroniser, then a tapped delay line
   logic miso_s1;
   logic miso_s2;
   logic [`QFC_CAP_TAPS-1:0] cap;

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         miso_s1 <= 1'b0;
         miso_s2 <= 1'b0;
      end else begin
         miso_s1 <= flash_miso;
         miso_s2 <= miso_s1;
      end
   end

   genvar gt;
   generate
      for (gt = 0; gt < `QFC_CAP_TAPS; gt++) begin : g_tap
         always_ff @(posedge clk_sys) begin
            if (!rstn) begin
               cap[gt] <= 1'b0;
            end else if (ref_tick) begin
               cap[gt] <= (gt == 0) ? miso_s2 : cap[(gt == 0) ? 0 : gt-1];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         rd_bit <= 1'b0;
      end else begin
         rd_bit <= cap[rd_capture_dly];
      end
   end

   // interrupt sources
   always_comb begin
      ibus.evt = '0;
      ibus.evt[`QFC_IRQ_UNDERFLOW] = dp_underrun;
      ibus.evt[`QFC_IRQ_IND_DONE] = ind_done;
      ibus.evt[`QFC_IRQ_IND_REJECT] = q_reject;
      ibus.evt[`QFC_IRQ_PROTECT] = prot_hit;
      ibus.evt[`QFC_IRQ_ILLEGAL] = dp_wrap_burst | dp_split | dp_retry;
      ibus.evt[`QFC_IRQ_WATERMARK] = wm_evt;
      ibus.evt[`QFC_IRQ_RX_OVF] = legacy_mode & rxf_push & rxf_full;
      ibus.evt[`QFC_IRQ_TX_NFULL] = legacy_mode & ~txf_full;
      ibus.evt[`QFC_IRQ_TX_FULL] = legacy_mode & txf_full;
      ibus.evt[`QFC_IRQ_RX_NEMPTY] = legacy_mode & ~rxf_empty;
      ibus.evt[`QFC_IRQ_RX_FULL] = legacy_mode & rxf_full;
      ibus.evt[`QFC_IRQ_RD_PART_OVF] = rd_ovf;
   end

   assign ibus.clr = irq_clr;
   assign ibus.mask = irq_mask;
   assign irq = ibus.irq;
   assign irq_status = ibus.status;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   sequence s_cs_release;
      cs_state == QFC_CS_ACTIVE ##1 cs_state == QFC_CS_GAP;
   endsequence

   sequence s_gap_hold;
      flash_cs_n [*3];
   endsequence

   chk_queue_bound: assert property (queue_level <= 2'h2)
      else $error("indirect queue above two");

   chk_reject_full: assert property (
      (ind_req && queue_level == 2'h2) |=> (!ind_accept && queue_level != 2'h3))
      else $error("request accepted with full queue");

   chk_rd_part_cap: assert property (rd_fill <= rd_cap(part_split))
      else $error("read partition beyond its share");

   chk_wr_part_cap: assert property (wr_fill <= wr_cap(part_split))
      else $error("write partition beyond its share");

   chk_protect_refuse: assert property (
      prot_hit |=> (xfer_refused && !xfer_go && irq_status[`QFC_IRQ_PROTECT]))
      else $error("protected write not refused");

   chk_remap_indirect: assert property (
      (xfer_req && !xfer_direct && !prot_hit && addr_bytes_4) |=> flash_addr == $past(xfer_addr))
      else $error("indirect address altered");

   chk_cs_gap_hold: assert property (
      (s_cs_release ##0 (cs_gap_dly != 8'h00)) |-> s_gap_hold)
      else $error("chip select reasserted inside gap");

   chk_sclk_idle: assert property (flash_cs_n |=> !flash_sclk)
      else $error("serial clock runs while deselected");

   chk_capture_tap: assert property (
      (ref_clk_en ##1 rd_capture_dly == 3'h0) |=> rd_bit == $past(miso_s2, 2))
      else $error("capture tap mismatch");

endmodule // qfc_ctrl

`default_nettype wire

// ---- qfc_defines.svh ----
// constants for the quad serial flash control block
`ifndef QFC_DEFINES_SVH
`define QFC_DEFINES_SVH

`define QFC_SRAM_DEPTH 8'h80
`define QFC_PART_DEFAULT 7'h40
`define QFC_QUEUE_MAX 2'h2
`define QFC_IRQ_W 12
`define QFC_CAP_TAPS 8

`define QFC_IRQ_UNDERFLOW 0
`define QFC_IRQ_IND_DONE 1
`define QFC_IRQ_IND_REJECT 2
`define QFC_IRQ_PROTECT 3
`define QFC_IRQ_ILLEGAL 4
`define QFC_IRQ_WATERMARK 5
`define QFC_IRQ_RX_OVF 6
`define QFC_IRQ_TX_NFULL 7
`define QFC_IRQ_TX_FULL 8
`define QFC_IRQ_RX_NEMPTY 9
`define QFC_IRQ_RX_FULL 10
`define QFC_IRQ_RD_PART_OVF 11

`define QFC_IRQ_LIVE_MASK 12'h780
`define QFC_ADDR3_MASK 32'h00ff_ffff

`endif

// ---- qfc_pkg.sv ----
// types of the quad serial flash control block
package qfc_pkg;

   typedef logic [11:0] qfc_irq_vec_t;

   typedef enum logic [1:0] {
      QFC_CS_IDLE = 2'h0,
      QFC_CS_ACTIVE = 2'h1,
      QFC_CS_GAP = 2'h3
   } qfc_cs_t;

endpackage

// ---- qfc_irq_if.sv ----
// interrupt carrier between the control core and the interrupt merger
`timescale 1ns/100ps
`default_nettype none

interface qfc_irq_if;
   import qfc_pkg::*;
   qfc_irq_vec_t evt;
   qfc_irq_vec_t clr;
   qfc_irq_vec_t mask;
   qfc_irq_vec_t status;
   logic irq;

   modport ctrl (output evt, output clr, output mask, input status, input irq);
   modport merge (input evt, input clr, input mask, output status, output irq);
endinterface

`default_nettype wire

// ---- qfc_irq.sv ----
// interrupt status, mask and merged level interrupt
`timescale 1ns/100ps
`default_nettype none
`include "qfc_defines.svh"

module qfc_irq
   import qfc_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // carrier
   qfc_irq_if.merge bus
);

   qfc_irq_vec_t live_sel;
   assign live_sel = `QFC_IRQ_LIVE_MASK;

   genvar gi;
   generate
      for (gi = 0; gi < `QFC_IRQ_W; gi++) begin : g_bit
         always_ff @(posedge clk_sys) begin
            if (!rstn) begin
               bus.status[gi] <= 1'b0;
            end else if (live_sel[gi]) begin
               bus.status[gi] <= bus.evt[gi];
            end else begin
               // a new event beats a clear in the same cycle
               bus.status[gi] <= bus.evt[gi] | (bus.status[gi] & ~bus.clr[gi]);
            end
         end
      end
   endgenerate

   assign bus.irq = |(bus.status & bus.mask);

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   chk_irq_merge_level: assert property (
      (|(bus.evt & bus.mask & ~live_sel)) ##1 $stable(bus.mask) |-> bus.irq)
      else $error("masked event did not raise the merged interrupt");

   chk_set_beats_clear: assert property (
      (bus.evt[`QFC_IRQ_RX_OVF] && bus.clr[`QFC_IRQ_RX_OVF]) |=> bus.status[`QFC_IRQ_RX_OVF])
      else $error("event lost against clear");

   chk_w1c_clears: assert property (
      (bus.status[`QFC_IRQ_UNDERFLOW] && bus.clr[`QFC_IRQ_UNDERFLOW]
       && !bus.evt[`QFC_IRQ_UNDERFLOW]) |=> !bus.status[`QFC_IRQ_UNDERFLOW])
      else $error("underflow flag did not clear on write one");

   chk_sticky_hold: assert property (
      (bus.status[`QFC_IRQ_IND_DONE] && !bus.clr[`QFC_IRQ_IND_DONE])
      |=> bus.status[`QFC_IRQ_IND_DONE])
      else $error("sticky flag dropped without clear");

endmodule // qfc_irq

`default_nettype wire

// ---- qfc_flash_model.sv ----
// serial flash partner: returns a toggling read bit on the data line
`timescale 1ns/100ps
`default_nettype none

module qfc_flash_model (
   // flash pins
   input wire logic flash_sclk,
   input wire logic flash_cs_n,
   output logic flash_miso
);
   initial flash_miso = 1'b0;
   // new bit on each falling serial clock while selected; every bit differs so
   // the bench can time each edge through the capture path
   // the line has no pull, so on release it shows the inverse of the last bit
   always @(negedge flash_sclk or posedge flash_cs_n) begin
      flash_miso <= ~flash_miso;
   end
endmodule // qfc_flash_model

`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the quad serial flash control core
`timescale 1ns/100ps
`default_nettype none

module tb_top;
   logic clk_sys = 1'b0, rstn = 1'b0, ref_clk_en = 1'b1, legacy_mode = 1'b0;
   logic addr_bytes_4 = 1'b1, wp_en = 1'b0, wp_inv = 1'b0, ind_req = 1'b0, ind_done = 1'b0;
   logic rd_push = 1'b0, rd_pop = 1'b0, wr_push = 1'b0, wr_pop = 1'b0, xfer_req = 1'b0;
   logic xfer_write = 1'b0, xfer_direct = 1'b0, dp_underrun = 1'b0, dp_wrap_burst = 1'b0;
   logic dp_split = 1'b0, dp_retry = 1'b0, rxf_push = 1'b0, rxf_full = 1'b0;
   logic rxf_empty = 1'b1, txf_full = 1'b0, cs_req = 1'b0;
   logic [3:0] baud_div = 4'h0;
   logic [7:0] cs_gap_dly = 8'h0, watermark = 8'h0;
   logic [2:0] rd_capture_dly = 3'h0;
   logic [4:0] block_shift = 5'h0, page_shift = 5'h8;
   logic [31:0] remap_offset = 32'h0, xfer_addr = 32'h0;
   logic [15:0] wp_low_blk = 16'h1, wp_high_blk = 16'h2;
   logic [6:0] part_split = 7'h40;
   logic [11:0] irq_mask = 12'h0, irq_clr = 12'h0;
   logic ind_accept, rd_room, wr_room, xfer_go, xfer_refused, page_last, flash_miso;
   logic flash_sclk, flash_cs_n, rd_bit, irq, v;
   logic [1:0] queue_level;
   logic [7:0] rd_fill, wr_fill;
   logic [31:0] flash_addr;
   logic [11:0] irq_status;
   logic [6:0] splits [3] = '{7'h40, 7'h00, 7'h7f};
   logic [2:0] dlys [2] = '{3'h0, 3'h5};
   int n_mismatch = 0, check_count = 0, k;

   qfc_ctrl u_qfc_ctrl (.clk_sys, .rstn, .ref_clk_en, .legacy_mode, .baud_div, .cs_gap_dly,
      .rd_capture_dly, .addr_bytes_4, .block_shift, .page_shift, .remap_offset, .wp_en,
      .wp_inv, .wp_low_blk, .wp_high_blk, .part_split, .watermark, .irq_mask, .irq_clr,
      .ind_req, .ind_done, .ind_accept, .queue_level, .rd_push, .rd_pop, .wr_push, .wr_pop,
      .rd_fill, .wr_fill, .rd_room, .wr_room, .xfer_req, .xfer_write, .xfer_direct,
      .xfer_addr, .dp_underrun, .dp_wrap_burst, .dp_split, .dp_retry, .xfer_go,
      .xfer_refused, .flash_addr, .page_last, .rxf_push, .rxf_full, .rxf_empty, .txf_full,
      .cs_req, .flash_miso, .flash_sclk, .flash_cs_n, .rd_bit, .irq, .irq_status);
   qfc_flash_model u_qfc_flash_model (.flash_sclk, .flash_cs_n, .flash_miso);

   initial forever #5 clk_sys = ~clk_sys;

   task wrap_up;
      if (n_mismatch == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // a wait that runs out is a failure, not a hang
   task automatic lim(input int n);
      if (n >= 200) begin
         n_mismatch++;
         wrap_up;
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic clr(input logic [11:0] m);
      @(posedge clk_sys) irq_clr <= m;
      @(posedge clk_sys) irq_clr <= 12'h0;
      cyc(1);
      #1;
   endtask
   // cycles until the serial clock (sel 0) or the data line (sel 1) changes
   task automatic wchg(input logic sel, output int n);
      logic old;
      old = sel ? flash_miso : flash_sclk;
      n = 0;
      do begin
         @(posedge clk_sys);
         #1;
         n++;
      end while ((sel ? flash_miso : flash_sclk) === old && n < 200);
      lim(n);
   endtask
   // push until room drops; the last push lands on a full partition
   task automatic fill(input logic rd, input logic [7:0] exp);
      int n;
      n = 0;
      @(posedge clk_sys);
      rd_push <= rd;
      wr_push <= !rd;
      #1;
      while ((rd ? rd_room : wr_room) === 1'b1 && n < 200) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      lim(n);
      @(posedge clk_sys);
      rd_push <= 1'b0;
      wr_push <= 1'b0;
      #1;
      chk(rd ? rd_fill : wr_fill, exp);
      chk(rd ? rd_room : wr_room, 1'b0);
   endtask
   task automatic drain;
      int n;
      n = 0;
      @(posedge clk_sys);
      rd_pop <= 1'b1;
      wr_pop <= 1'b1;
      #1;
      while ((rd_fill | wr_fill) != 8'h0 && n < 200) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      lim(n);
      @(posedge clk_sys);
      rd_pop <= 1'b0;
      wr_pop <= 1'b0;
      #1;
      chk({rd_fill, wr_fill}, 16'h0);
   endtask
   task automatic xfer(input logic w, input logic d, input logic [31:0] a, input logic go,
                       input logic [31:0] fa);
      @(posedge clk_sys);
      xfer_req <= 1'b1;
      xfer_write <= w;
      xfer_direct <= d;
      xfer_addr <= a;
      @(posedge clk_sys);
      xfer_req <= 1'b0;
      #1;
      chk({xfer_go, xfer_refused}, {go, !go});
      chk(flash_addr, fa);
      if (go) chk(page_last, w && (a[7:0] == 8'hff));
      cyc(2);
      #1;
      chk(irq_status[3], !go);
      clr(12'h008);
   endtask

   initial begin
      repeat (20) @(posedge clk_sys);
      #1;
      chk({flash_cs_n, rd_room, wr_room, irq, irq_status, queue_level, rd_fill},
          {4'he, 22'h0});
      @(posedge clk_sys) rstn <= 1'b1;
      cyc(2);
      // sticky event flags, level merge and mask, write-one clear
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_sys) {dp_underrun, dp_wrap_burst, dp_split, dp_retry} <= 4'h1 << i;
         @(posedge clk_sys) {dp_underrun, dp_wrap_burst, dp_split, dp_retry} <= 4'h0;
         cyc(20);
         #1;
         chk(irq_status, (i == 3) ? 12'h001 : 12'h010);
         chk(irq, 1'b0);
         @(posedge clk_sys) irq_mask <= irq_status;
         cyc(1);
         #1;
         chk(irq, 1'b1);
         clr(irq_status);
         chk({irq_status, irq}, 13'h0);
         @(posedge clk_sys) irq_mask <= 12'h0;
      end
      // third back-to-back request finds the queue full
      @(posedge clk_sys) ind_req <= 1'b1;
      @(posedge clk_sys);
      #1;
      chk({ind_accept, queue_level}, 3'h5);
      cyc(2);
      ind_req <= 1'b0;
      #1;
      chk({ind_accept, queue_level}, 3'h2);
      cyc(2);
      #1;
      chk(irq_status, 12'h004);
      @(posedge clk_sys) ind_done <= 1'b1;
      cyc(2);
      ind_done <= 1'b0;
      cyc(2);
      #1;
      chk({irq_status, queue_level}, {12'h006, 2'h0});
      clr(12'hfff);
      // partitions with one operation pending, so a full read side overflows
      @(posedge clk_sys) ind_req <= 1'b1;
      @(posedge clk_sys) ind_req <= 1'b0;
      watermark <= 8'h10;
      foreach (splits[i]) begin
         @(posedge clk_sys) part_split <= splits[i];
         fill(1'b1, {1'b0, splits[i]} + 8'h1);
         fill(1'b0, 8'h80 - {1'b0, splits[i]});
         cyc(2);
         #1;
         chk(irq_status[11], 1'b1);
         chk(irq_status[5], {1'b0, splits[i]} >= 8'h0f);
         clr(12'hfff);
         drain;
      end
      @(posedge clk_sys) ind_done <= 1'b1;
      @(posedge clk_sys) ind_done <= 1'b0;
      clr(12'h002);
      // queue drained, then configuration in order; mode bits stay with software
      @(posedge clk_sys) wp_en <= 1'b1;
      remap_offset <= 32'h100;
      block_shift <= 5'hc;
      xfer(1'b1, 1'b0, 32'h1000, 1'b0, 32'h0);
      xfer(1'b1, 1'b0, 32'h2fff, 1'b0, 32'h0);
      xfer(1'b1, 1'b0, 32'h30ff, 1'b1, 32'h30ff);
      xfer(1'b0, 1'b0, 32'h2000, 1'b1, 32'h2000);
      xfer(1'b0, 1'b1, 32'h2000, 1'b1, 32'h2100);
      @(posedge clk_sys) addr_bytes_4 <= 1'b0;
      wp_inv <= 1'b1;
      xfer(1'b0, 1'b0, 32'h1234_5678, 1'b1, 32'h0034_5678);
      xfer(1'b1, 1'b0, 32'h1000, 1'b1, 32'h1000);
      xfer(1'b1, 1'b0, 32'h3000, 1'b0, 32'h1000);
      // legacy live conditions and receive overflow
      @(posedge clk_sys) legacy_mode <= 1'b1;
      rxf_full <= 1'b1;
      rxf_empty <= 1'b0;
      cyc(3);
      #1;
      chk(irq_status, 12'h680);
      @(posedge clk_sys) {txf_full, rxf_full, rxf_empty} <= 3'b101;
      cyc(3);
      #1;
      chk(irq_status, 12'h100);
      @(posedge clk_sys) {txf_full, rxf_full} <= 2'b01;
      rxf_push <= 1'b1;
      @(posedge clk_sys) rxf_push <= 1'b0;
      cyc(2);
      #1;
      chk(irq_status[6], 1'b1);
      @(posedge clk_sys) rxf_push <= 1'b1;
      irq_clr <= 12'h040;
      @(posedge clk_sys) rxf_push <= 1'b0;
      irq_clr <= 12'h0;
      cyc(2);
      #1;
      chk(irq_status[6], 1'b1);
      clr(12'h040);
      chk(irq_status[6], 1'b0);
      @(posedge clk_sys) legacy_mode <= 1'b0;
      rxf_push <= 1'b1;
      @(posedge clk_sys) rxf_push <= 1'b0;
      cyc(3);
      #1;
      chk(irq_status, 12'h0);
      // gated reference clock, serial divide, capture delay, deselect gap
      @(posedge clk_sys) ref_clk_en <= 1'b0;
      cs_req <= 1'b1;
      baud_div <= 4'h7;
      cs_gap_dly <= 8'h0c;
      cyc(10);
      #1;
      chk({flash_cs_n, flash_sclk}, 2'b10);
      @(posedge clk_sys) ref_clk_en <= 1'b1;
      cyc(3);
      #1;
      chk(flash_cs_n, 1'b0);
      wchg(1'b0, k);
      wchg(1'b0, k);
      chk(k, 32'h8);
      foreach (dlys[i]) begin
         @(posedge clk_sys) rd_capture_dly <= dlys[i];
         cyc(20);
         #1;
         wchg(1'b1, k);
         v = flash_miso;
         repeat (dlys[i] + 3) @(posedge clk_sys);
         #1;
         chk(rd_bit, !v);
         @(posedge clk_sys);
         #1;
         chk(rd_bit, v);
      end
      @(posedge clk_sys) cs_req <= 1'b0;
      @(posedge clk_sys) cs_req <= 1'b1;
      #1;
      k = 0;
      while (flash_cs_n === 1'b1 && k < 200) begin
         k++;
         @(posedge clk_sys);
         #1;
      end
      lim(k);
      chk(k >= 12, 1'b1);
      // reset in mid-run drops the sticky flags
      @(posedge clk_sys) dp_underrun <= 1'b1;
      irq_mask <= 12'h001;
      @(posedge clk_sys) dp_underrun <= 1'b0;
      #1;
      chk(irq, 1'b1);
      @(posedge clk_sys) rstn <= 1'b0;
      cyc(2);
      #1;
      chk({irq_status, queue_level, flash_cs_n}, 15'h1);
      @(posedge clk_sys) rstn <= 1'b1;
      cyc(2);
      wrap_up;
   end
endmodule // tb_top

`default_nettype wire
